// ===== inc/cfb_pkg.sv
// Constants shared by the buffer core, its memory and its bus registers.
// Assumes a 32-bit classic Wishbone slave addressed in bytes.
package cfb_pkg;

	// ***********************************************
	// Register offsets
	// ***********************************************
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_PFULL   = 8'h04;
	localparam logic [7:0] REG_PEMPTY  = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_WRCNT   = 8'h10;
	localparam logic [7:0] REG_RDCNT   = 8'h14;
	localparam logic [7:0] REG_DCNT    = 8'h18;
	localparam logic [7:0] REG_INTST   = 8'h1c;
	localparam logic [7:0] REG_INTMASK = 8'h20;

	// ***********************************************
	// Fields and reset values
	// ***********************************************
	localparam int         CTRL_LOOK   = 0;
	localparam int         CTRL_OUTREG = 1;
	localparam int         CTRL_INJECT = 2;
	localparam logic [2:0] CTRL_RST    = 3'h0;
	localparam int         ST_FULL     = 0;
	localparam int         ST_EMPTY    = 1;
	localparam int         ST_AFULL    = 2;
	localparam int         ST_AEMPTY   = 3;
	localparam int         ST_PFULL    = 4;
	localparam int         ST_PEMPTY   = 5;
	localparam int         INT_OVER    = 0;
	localparam int         INT_UNDER   = 1;
	localparam int         INT_ECC     = 2;
	localparam logic [2:0] INT_RST     = 3'h0;

	// ***********************************************
	// Build choices and limits
	// ***********************************************
	localparam logic [1:0] IMPL_BRAM       = 2'h0;
	localparam logic [1:0] IMPL_DIST       = 2'h1;
	localparam logic [1:0] IMPL_SHIFT      = 2'h2;
	localparam logic [1:0] IMPL_MACRO      = 2'h3;
	localparam int         MACRO_MAX_DEPTH = 8192;
	localparam int         MAX_RATIO       = 8;
	localparam int         PIECE_W         = 4;
	localparam int         INJECT_BIT      = 2;

	typedef enum logic [1:0]
	{
		WB_IDLE = 2'b01,
		WB_ACK  = 2'b10
	} cfb_wb_state_t;

endpackage

// ===== inc/cfb_mem_if.sv
// Port bundle between the buffer core and its storage array.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cfb_mem_if
#(
	parameter int AW = 9,
	parameter int DW = 12
);
	logic          wrEn;
	logic [AW-1:0] wrAddr;
	logic [DW-1:0] wrData;
	logic          rdEn;
	logic [AW-1:0] rdAddr;
	logic [DW-1:0] rdData;

	modport ctrl (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
	modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

// ===== design/cfb_mem.sv
// Simple dual-port storage array with registered read data.
// Assumes the core never reads an entry in the cycle it is written.
`timescale 1ns/1ps
module cfb_mem
#(
	parameter int AW    = 9,
	parameter int DW    = 12,
	parameter int DEPTH = 512
)
(
	// Clock.
	input wire logic clock,
	// Storage port.
	cfb_mem_if.mem   port
);

	logic [DW-1:0] store [DEPTH];

	// Read data is held in a register so the array maps onto RAM blocks.
	always_ff @(posedge clock)
	begin
		if (port.wrEn)
		begin
			store[port.wrAddr] <= port.wrData;
		end
		if (port.rdEn)
		begin
			port.rdData <= store[port.rdAddr];
		end
	end

endmodule

// ===== design/cfb_top.sv
// Configurable first-in first-out buffer with width conversion, look-ahead
// output, status flags, counts, handshake flags, ECC and Wishbone registers.
// Assumes one clock for writer, reader and bus master.
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
module cfb_top
#(
	parameter int         WR_W              = 8,
	parameter int         RD_W              = 8,
	parameter int         DEPTH             = 512,
	parameter logic [1:0] IMPL              = cfb_pkg::IMPL_BRAM,
	parameter bit         ASYNC_RESET       = 1'b0,
	parameter bit         HANDSHAKE_EN      = 1'b1,
	parameter bit         COUNT_EN          = 1'b1,
	parameter bit         ECC_EN            = 1'b1,
	parameter bit         MACRO_DIRECT_PROG = 1'b0,
	parameter int         PFULL_RST         = 500,
	parameter int         PEMPTY_RST        = 2,
	parameter logic [RD_W-1:0] DOUT_RESET_VAL = '0
)
(
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Wishbone register port.
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [31:0]       dat_i,
	input  wire logic [3:0]        sel_i,
	output      logic [31:0]       dat_o,
	output wire logic              ack_o,
	output wire logic              irq,
	// Write side.
	input  wire logic              wrEn,
	input  wire logic [WR_W-1:0]   wrData,
	output wire logic              wrReady,
	output wire logic              wrAck,
	output wire logic              overflow,
	output wire logic              full,
	output wire logic              macro_near_full_flag,
	output wire logic              progFull,
	output wire logic [15:0]       wrCount,
	// Read side.
	input  wire logic              rdEn,
	output      logic [RD_W-1:0]   rdData,
	output      logic              rdValid,
	output wire logic              underflow,
	output wire logic              empty,
	output wire logic              macro_near_empty_flag,
	output wire logic              progEmpty,
	output wire logic [15:0]       rdCount,
	output wire logic [15:0]       dataCount
);

	// ***********************************************
	// Sizes
	// ***********************************************
	localparam int MEM_W = (WR_W > RD_W) ? WR_W : RD_W;
	localparam int WR_PER = MEM_W / WR_W;
	localparam int RD_PER = MEM_W / RD_W;
	localparam bit IS_MACRO = IMPL == cfb_pkg::IMPL_MACRO;
	localparam int EFF_DEPTH = (IS_MACRO && WR_W != RD_W &&
		DEPTH > cfb_pkg::MACRO_MAX_DEPTH) ? cfb_pkg::MACRO_MAX_DEPTH : DEPTH;
	localparam int AW = $clog2(EFF_DEPTH);
	localparam int MC_W = $clog2(EFF_DEPTH + 1);
	localparam int CNT_W = $clog2(EFF_DEPTH * cfb_pkg::MAX_RATIO + 16);
	localparam int PAR_W = $clog2(MEM_W + $clog2(MEM_W) + 2);
	localparam int CW = MEM_W + PAR_W;
	localparam int PW = cfb_pkg::PIECE_W;

	typedef struct packed
	{
		logic [AW-1:0]    wrPtr;
		logic [AW-1:0]    rdPtr;
		logic [MC_W-1:0]  memCount;
		logic [MEM_W-1:0] packReg;
		logic [PW-1:0]    packFill;
		logic             pending;
		logic [MEM_W-1:0] stage;
		logic [PW-1:0]    stagePieces;
		logic [RD_W-1:0]  s1Data;
		logic             s1Valid;
		logic             wrAck;
		logic             overflow;
		logic             underflow;
		logic             eccHit;
	} cfb_core_t;

	cfb_core_t                core;
	cfb_core_t                next_core;
	logic [RD_W-1:0]          next_rdData;
	logic                     next_rdValid;
	logic                     arstN;
	logic                     srstN;
	logic                     wrFire;
	logic                     rdPop;
	logic                     packDone;
	logic                     memWr;
	logic                     memRd;
	logic [MEM_W-1:0]         assembled;
	logic [MEM_W:0]           decoded;
	logic [CNT_W-1:0]         dataCountInt;
	logic [CNT_W-1:0]         wrCountInt;
	logic [CNT_W-1:0]         rdCountInt;
	logic                     macroNearFullFlag;
	logic                     macroNearEmptyFlag;
	logic                     lookaheadReadMode;
	logic                     outputRegMode;
	cfb_pkg::cfb_wb_state_t   wbState;
	cfb_pkg::cfb_wb_state_t   next_wbState;
	logic [2:0]               ctrl;
	logic [2:0]               next_ctrl;
	logic [CNT_W-1:0]         pFullThr;
	logic [CNT_W-1:0]         next_pFullThr;
	logic [CNT_W-1:0]         pEmptyThr;
	logic [CNT_W-1:0]         next_pEmptyThr;
	logic [2:0]               intStatus;
	logic [2:0]               next_intStatus;
	logic [2:0]               intMask;
	logic [2:0]               next_intMask;
	logic [31:0]              next_dat_o;
	logic [31:0]              readMux;
	logic [5:0]               statusWord;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ***********************************************
	// Helpers
	// ***********************************************
	function automatic logic [AW-1:0] ptrNext(input logic [AW-1:0] p);
		return (p == AW'(EFF_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [31:0] wbMerge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] m;
		for (int b = 0; b < 4; b++)
			m[b*8 +: 8] = {8{sel[b]}};
		return (old & ~m) | (dat & m);
	endfunction

	// Hamming code: parity sits at power-of-two positions, data elsewhere.
	function automatic logic [CW-1:0] eccEncode(input logic [MEM_W-1:0] d);
		logic [CW-1:0] c;
		int            j;
		c = '0;
		j = 0;
		for (int k = 1; k <= CW; k++)
			if ((k & (k - 1)) != 0 && j < MEM_W)
			begin
				c[k-1] = d[j];
				j++;
			end
		for (int k = 1; k <= CW; k++)
			for (int b = 0; b < PAR_W; b++)
				if (((k >> b) & 1) != 0 && k != (1 << b) && (1 << b) <= CW)
					c[(1 << b) - 1] = c[(1 << b) - 1] ^ c[k-1];
		return c;
	endfunction

	function automatic logic [MEM_W:0] eccDecode(input logic [CW-1:0] cin);
		logic [CW-1:0]    c;
		logic [PAR_W-1:0] s;
		logic [MEM_W-1:0] d;
		int               j;
		c = cin;
		s = '0;
		d = '0;
		j = 0;
		for (int k = 1; k <= CW; k++)
			if (c[k-1])
				s = s ^ PAR_W'(k);
		if (ECC_EN && s != '0 && int'(s) <= CW)
			c[int'(s) - 1] = ~c[int'(s) - 1];
		for (int k = 1; k <= CW; k++)
			if ((k & (k - 1)) != 0 && j < MEM_W)
			begin
				d[j] = c[k-1];
				j++;
			end
		return {ECC_EN && s != '0, d};
	endfunction

	// ***********************************************
	// Storage
	// ***********************************************
	cfb_mem_if #(.AW(AW), .DW(CW)) mif ();

	cfb_mem #(.AW(AW), .DW(CW), .DEPTH(EFF_DEPTH)) storage
	(
		.clock (clock),
		.port  (mif.mem)
	);

	assign mif.wrData = eccEncode(assembled) ^
		((ECC_EN && ctrl[cfb_pkg::CTRL_INJECT]) ?
		CW'(1) << cfb_pkg::INJECT_BIT : CW'(0));
	assign mif.wrEn = memWr;
	assign mif.wrAddr = core.wrPtr;
	assign mif.rdEn = memRd;
	assign mif.rdAddr = core.rdPtr;
	assign decoded = eccDecode(mif.rdData);

	// ***********************************************
	// Buffer core
	// ***********************************************
	// build-time reset style.
	assign arstN = ASYNC_RESET ? rst_n : 1'b1;
	assign srstN = ASYNC_RESET ? 1'b1 : rst_n;
	assign lookaheadReadMode = ctrl[cfb_pkg::CTRL_LOOK];
	assign outputRegMode = ctrl[cfb_pkg::CTRL_OUTREG];
	assign full = core.memCount == MC_W'(EFF_DEPTH);
	assign empty = core.stagePieces == '0;
	assign wrFire = wrEn && !full;
	assign rdPop = rdEn && !empty;
	assign packDone = core.packFill == PW'(WR_PER - 1);
	// narrow writes pack low pieces first.
	assign assembled = core.packReg |
		(MEM_W'(wrData) << (int'(core.packFill) * WR_W));
	assign memWr = wrFire && packDone;
	// One fetch in flight keeps the stage logic free of read hazards.
	assign memRd = !core.pending && core.memCount != '0 &&
		(empty || (rdPop && core.stagePieces == PW'(1)));

	always_comb
	begin
		next_core = core;
		if (wrFire)
		begin
			next_core.packReg = packDone ? '0 : assembled;
			next_core.packFill = packDone ? '0 : core.packFill + 1'b1;
		end
		if (memWr)
			next_core.wrPtr = ptrNext(core.wrPtr);
		if (memRd)
			next_core.rdPtr = ptrNext(core.rdPtr);
		next_core.memCount = core.memCount + MC_W'(memWr) - MC_W'(memRd);
		next_core.pending = memRd;
		// wide words leave in read-width pieces.
		if (core.pending)
		begin
			next_core.stage = decoded[MEM_W-1:0];
			next_core.stagePieces = PW'(RD_PER);
		end
		else if (rdPop)
		begin
			next_core.stage = core.stage >> RD_W;
			next_core.stagePieces = core.stagePieces - 1'b1;
		end
		next_core.s1Data = rdPop ? core.stage[RD_W-1:0] : core.s1Data;
		next_core.s1Valid = rdPop;
		next_core.wrAck = wrFire;
		next_core.overflow = wrEn && full;
		next_core.underflow = rdEn && empty;
		next_core.eccHit = core.pending && decoded[MEM_W];
	end

	always_ff @(posedge clock or negedge arstN)
	begin
		if (!arstN)
			core <= '0;
		else if (!srstN)
			core <= '0;
		else
			core <= next_core;
	end

	// ***********************************************
	// Read output stage
	// ***********************************************
	always_comb
	begin
		next_rdData = rdData;
		next_rdValid = 1'b0;
		if (lookaheadReadMode)
		begin
			next_rdData = next_core.stage[RD_W-1:0];
			next_rdValid = next_core.stagePieces != '0;
		end
		else if (outputRegMode)
		begin
			if (core.s1Valid)
				next_rdData = core.s1Data;
			next_rdValid = core.s1Valid;
		end
		else
		begin
			if (rdPop)
				next_rdData = core.stage[RD_W-1:0];
			next_rdValid = rdPop;
		end
	end

	always_ff @(posedge clock or negedge arstN)
	begin
		if (!arstN)
		begin
			rdData <= DOUT_RESET_VAL;
			rdValid <= 1'b0;
		end
		else if (!srstN)
		begin
			rdData <= DOUT_RESET_VAL;
			rdValid <= 1'b0;
		end
		else
		begin
			rdData <= next_rdData;
			rdValid <= next_rdValid;
		end
	end

	// ***********************************************
	// Flags and counts
	// ***********************************************
	// both sides share this clock.
	assign dataCountInt = CNT_W'(core.memCount) + CNT_W'(core.pending) +
		CNT_W'(!empty);
	assign wrCountInt = CNT_W'(dataCountInt * WR_PER) + CNT_W'(core.packFill);
	assign rdCountInt = CNT_W'((CNT_W'(core.memCount) +
		CNT_W'(core.pending)) * RD_PER) + CNT_W'(core.stagePieces);
	assign macroNearFullFlag = core.memCount >= MC_W'(EFF_DEPTH - 1);
	assign macroNearEmptyFlag = rdCountInt <= CNT_W'(1);
	assign macro_near_full_flag = !IS_MACRO && macroNearFullFlag;
	assign macro_near_empty_flag = !IS_MACRO && macroNearEmptyFlag;
	assign progFull = (IS_MACRO && MACRO_DIRECT_PROG) ? macroNearFullFlag :
		wrCountInt >= pFullThr;
	assign progEmpty = (IS_MACRO && MACRO_DIRECT_PROG) ? macroNearEmptyFlag :
		rdCountInt <= pEmptyThr;
	assign wrCount = (COUNT_EN && !IS_MACRO) ? 16'(wrCountInt) : 16'h0000;
	assign rdCount = (COUNT_EN && !IS_MACRO) ? 16'(rdCountInt) : 16'h0000;
	assign dataCount = (COUNT_EN && !IS_MACRO) ? 16'(dataCountInt) : 16'h0000;
	assign wrReady = !full;
	assign wrAck = HANDSHAKE_EN && core.wrAck;
	assign overflow = HANDSHAKE_EN && core.overflow;
	assign underflow = HANDSHAKE_EN && core.underflow;

	look_show_a: assert property (
		lookaheadReadMode && empty && core.memCount != '0 |-> ##[1:3] rdValid)
		else $error("Look-ahead word did not appear.");
	pack_flush_a: assert property (
		wrFire && packDone && !memRd
		|=> core.memCount == $past(core.memCount) + 1'b1)
		else $error("Packed word was not stored.");
	depth_cap_a: assert property (
		core.memCount <= MC_W'(EFF_DEPTH))
		else $error("Depth limit exceeded.");
	out_delay_a: assert property (
		!lookaheadReadMode && outputRegMode && rdPop && !core.s1Valid
		|=> !rdValid ##1 rdValid)
		else $error("Output register delay wrong.");
	look_hold_a: assert property (
		lookaheadReadMode && rdValid && !rdEn |=> rdValid && $stable(rdData))
		else $error("Presented word not held.");
	reset_value_a: assert property (
		$rose(rst_n) |-> rdData == DOUT_RESET_VAL)
		else $error("Read data reset value wrong.");
	full_flags_a: assert property (
		full |-> !wrReady && (macro_near_full_flag || IS_MACRO))
		else $error("Full flags disagree.");
	wr_ack_a: assert property (
		wrFire |=> wrAck == HANDSHAKE_EN)
		else $error("Write acknowledge missing.");
	over_drop_a: assert property (
		wrEn && full
		|=> overflow == HANDSHAKE_EN && core.memCount <= $past(core.memCount))
		else $error("Overflow not flagged.");
	under_drop_a: assert property (
		rdEn && empty |=> underflow == HANDSHAKE_EN && !core.s1Valid)
		else $error("Underflow not flagged.");
	count_zero_a: assert property (
		empty && core.memCount == '0 && !core.pending |-> dataCount == '0)
		else $error("Word count not zero.");
	count_pair_a: assert property (
		wrCountInt == '0 |-> rdCountInt == '0)
		else $error("Side counts disagree.");
	macro_flags_a: assert property (
		IS_MACRO |-> !macro_near_full_flag && !macro_near_empty_flag &&
		(!MACRO_DIRECT_PROG || progFull == macroNearFullFlag))
		else $error("Macro flags wrong.");
	ecc_flag_a: assert property (
		core.pending && decoded[MEM_W] |-> ##2 intStatus[cfb_pkg::INT_ECC])
		else $error("Correction event lost.");
	ready_valid_a: assert property (
		lookaheadReadMode && $past(lookaheadReadMode) |-> rdValid == !empty)
		else $error("Valid does not follow data.");

	// ***********************************************
	// Wishbone registers and interrupt
	// ***********************************************
	assign statusWord = {progEmpty, progFull, macro_near_empty_flag, macro_near_full_flag,
		empty, full};
	assign ack_o = wbState == cfb_pkg::WB_ACK;
	assign irq = |(intStatus & intMask);

	always_comb
	begin
		readMux = 32'h00000000;
		if (adr_i == cfb_pkg::REG_CTRL)
			readMux = 32'(ctrl);
		else if (adr_i == cfb_pkg::REG_PFULL)
			readMux = 32'(pFullThr);
		else if (adr_i == cfb_pkg::REG_PEMPTY)
			readMux = 32'(pEmptyThr);
		else if (adr_i == cfb_pkg::REG_STATUS)
			readMux = 32'(statusWord);
		else if (adr_i == cfb_pkg::REG_WRCNT)
			readMux = 32'(wrCount);
		else if (adr_i == cfb_pkg::REG_RDCNT)
			readMux = 32'(rdCount);
		else if (adr_i == cfb_pkg::REG_DCNT)
			readMux = 32'(dataCount);
		else if (adr_i == cfb_pkg::REG_INTST)
			readMux = 32'(intStatus);
		else if (adr_i == cfb_pkg::REG_INTMASK)
			readMux = 32'(intMask);
	end

	always_comb
	begin
		next_wbState = wbState;
		next_ctrl = ctrl;
		next_pFullThr = pFullThr;
		next_pEmptyThr = pEmptyThr;
		next_intMask = intMask;
		next_dat_o = dat_o;
		next_intStatus = intStatus;
		case (wbState)
			cfb_pkg::WB_IDLE:
			begin
				if (cyc_i && stb_i)
				begin
					next_wbState = cfb_pkg::WB_ACK;
					next_dat_o = readMux;
				end
			end
			cfb_pkg::WB_ACK:
			begin
				next_wbState = cfb_pkg::WB_IDLE;
			end
			default:
			begin
				next_wbState = cfb_pkg::WB_IDLE;
			end
		endcase
		// Writes land on the acknowledged edge; unmapped offsets are ignored.
		if (ack_o && cyc_i && stb_i && we_i)
		begin
			if (adr_i == cfb_pkg::REG_CTRL)
				next_ctrl = 3'(wbMerge(32'(ctrl), dat_i, sel_i));
			else if (adr_i == cfb_pkg::REG_PFULL)
				next_pFullThr = CNT_W'(wbMerge(32'(pFullThr), dat_i, sel_i));
			else if (adr_i == cfb_pkg::REG_PEMPTY)
				next_pEmptyThr = CNT_W'(wbMerge(32'(pEmptyThr), dat_i, sel_i));
			else if (adr_i == cfb_pkg::REG_INTST)
				next_intStatus = intStatus & ~(sel_i[0] ? dat_i[2:0] : 3'h0);
			else if (adr_i == cfb_pkg::REG_INTMASK)
				next_intMask = 3'(wbMerge(32'(intMask), dat_i, sel_i));
		end
		// A new event outranks a clear in the same cycle.
		next_intStatus = next_intStatus |
			{core.eccHit, core.underflow, core.overflow};
	end

	always_ff @(posedge clock or negedge arstN)
	begin
		// The synchronous clear stays out of the asynchronous condition.
		if (!arstN)
		begin
			wbState <= cfb_pkg::WB_IDLE;
			ctrl <= cfb_pkg::CTRL_RST;
			pFullThr <= CNT_W'(PFULL_RST);
			pEmptyThr <= CNT_W'(PEMPTY_RST);
			intStatus <= cfb_pkg::INT_RST;
			intMask <= cfb_pkg::INT_RST;
			dat_o <= 32'h00000000;
		end
		else if (!srstN)
		begin
			wbState <= cfb_pkg::WB_IDLE;
			ctrl <= cfb_pkg::CTRL_RST;
			pFullThr <= CNT_W'(PFULL_RST);
			pEmptyThr <= CNT_W'(PEMPTY_RST);
			intStatus <= cfb_pkg::INT_RST;
			intMask <= cfb_pkg::INT_RST;
			dat_o <= 32'h00000000;
		end
		else
		begin
			wbState <= next_wbState;
			ctrl <= next_ctrl;
			pFullThr <= next_pFullThr;
			pEmptyThr <= next_pEmptyThr;
			intStatus <= next_intStatus;
			intMask <= next_intMask;
			dat_o <= next_dat_o;
		end
	end

endmodule

// ===== verification/cfb_reader.sv
// Read-side user logic model that drives the buffer's read request.
// Assumes the bench raises go and bad just after a clock edge.
`timescale 1ns/1ps
module cfb_reader
(
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst_n,
	// Control from the bench.
	input  wire logic go,
	input  wire logic bad,
	// Buffer read port.
	input  wire logic empty,
	output      logic rdEn
);
	// no go-driven read when empty; bad forces a read regardless
	// Go-driven reads never come in adjacent cycles, since the flag after a pop
	// is not yet settled when the next request would be set.
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rdEn <= 1'b0;
		else
			rdEn <= bad || (go && !rdEn && !empty && $urandom % 2 == 1);
	end
endmodule

// ===== verification/cfb_top_tb_top.sv
// Self-checking bench for the buffer core with a read-side model.
// Assumes one clock for the bus, the writer and the reader.
`timescale 1ns/1ps
module cfb_top_tb_top;
	logic        clock, rst_n, cyc, stb, we, wrEn, go, bad, rdEn, la;
	logic        ack, irq, wrReady, wrAck, overflow, full, aFull, pFull;
	logic        rdValid, underflow, empty, aEmpty, pEmpty;
	logic [7:0]  adr, wrData, rdData, d;
	logic [31:0] dat, datO;
	logic [15:0] wrCount, rdCount, dataCount;
	logic [7:0]  exp[$];
	int          fails, checks, ticks, nOver, nUnder, nAck;

	cfb_top #(.DEPTH(8), .PFULL_RST(6)) dut
	(
		.clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(4'hf),
		.dat_o(datO), .ack_o(ack), .irq(irq), .wrEn(wrEn),
		.wrData(wrData), .wrReady(wrReady), .wrAck(wrAck),
		.overflow(overflow), .full(full), .macro_near_full_flag(aFull),
		.progFull(pFull), .wrCount(wrCount), .rdEn(rdEn),
		.rdData(rdData), .rdValid(rdValid), .underflow(underflow),
		.empty(empty), .macro_near_empty_flag(aEmpty), .progEmpty(pEmpty),
		.rdCount(rdCount), .dataCount(dataCount)
	);
	cfb_reader u_rd
	(
		.clock(clock), .rst_n(rst_n), .go(go), .bad(bad),
		.empty(empty), .rdEn(rdEn)
	);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// The request stands until ack is seen; a read returns in datO.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do @(posedge clock); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [31:0] stExp(input bit f, e, af, ae, pf, pe);
		return 32'(f) << cfb_pkg::ST_FULL | 32'(e) << cfb_pkg::ST_EMPTY |
			32'(af) << cfb_pkg::ST_AFULL | 32'(ae) << cfb_pkg::ST_AEMPTY |
			32'(pf) << cfb_pkg::ST_PFULL | 32'(pe) << cfb_pkg::ST_PEMPTY;
	endfunction

	// Accepted words are queued at the edge the buffer takes them.
	task automatic push(input int n);
		for (int i = 0; i < n + 2; i++)
		begin
			@(posedge clock);
			if (wrEn === 1'b1 && full === 1'b0)
				exp.push_back(wrData);
			wrEn <= i < n;
			wrData <= 8'($urandom);
		end
	endtask

	task automatic drain;
		go <= 1'b1;
		while (exp.size() != 0) @(posedge clock);
		go <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	initial
	begin
		clock = 1'b0;
	end

	// Hangs are cut short by a cycle ceiling well above the run length.
	always @(posedge clock)
	begin
		ticks++;
		nOver += int'(overflow === 1'b1);
		nUnder += int'(underflow === 1'b1);
		nAck += int'(wrAck === 1'b1);
		if (rdValid === 1'b1 && !la)
			chk(rdData, exp.size() ? exp.pop_front() : 'x);
		if (ticks == 20000)
		begin
			fails++;
			end_sim();
		end
	end

	initial
	begin
		{rst_n, cyc, stb, we, wrEn, go, bad, la} = '0;
		{adr, wrData, dat} = '0;
		void'($urandom(32'hbae0));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk(rdData, 0);
		chk(wrReady, 1);
		chk({aFull, pFull, aEmpty, pEmpty}, 4'h3);
		wb(0, cfb_pkg::REG_STATUS, 0);
		chk(datO, stExp(0, 1, 0, 1, 0, 1));
		wb(0, 8'h40, 0);
		chk(datO, 0);
		wb(1, cfb_pkg::REG_INTMASK, 32'h3);
		push(16);
		repeat (2) @(posedge clock);
		chk(wrReady, 0);
		chk(nAck, exp.size());
		chk(dataCount, exp.size());
		chk(wrCount, exp.size());
		chk(rdCount, exp.size());
		chk({aFull, pFull, aEmpty, pEmpty}, 4'hc);
		chk(32'(nOver > 0), 1);
		chk(irq, 1);
		wb(0, cfb_pkg::REG_STATUS, 0);
		chk(datO, stExp(1, 0, 1, 0, 1, 0));
		wb(1, cfb_pkg::REG_INTST, 32'h1);
		repeat (2) @(posedge clock);
		chk(irq, 0);
		drain();
		chk(empty, 1);
		chk(dataCount, 0);
		bad <= 1'b1;
		@(posedge clock);
		bad <= 1'b0;
		repeat (4) @(posedge clock);
		chk(32'(nUnder > 0), 1);
		chk(irq, 1);
		la <= 1'b1;
		wb(1, cfb_pkg::REG_CTRL, 32'h1);
		d = 8'($urandom);
		@(posedge clock);
		wrEn <= 1'b1;
		wrData <= d;
		@(posedge clock);
		wrEn <= 1'b0;
		repeat (8) @(posedge clock);
		chk(rdValid, 1);
		chk(rdData, d);
		chk(dataCount, 1);
		exp.push_back(d);
		wb(1, cfb_pkg::REG_CTRL, 32'h6);
		@(posedge clock);
		la <= 1'b0;
		push(3);
		drain();
		wb(0, cfb_pkg::REG_INTST, 0);
		chk(datO, (1 << cfb_pkg::INT_ECC) | (1 << cfb_pkg::INT_UNDER));
		end_sim();
	end
endmodule
